//--- pkg/ddrarb_pkg.sv
// Purpose: Shared constants, codes and carriers of the DDR arbiter/refresh block.
// Assumes: Core clock of 10 MHz; two chip selects.
// Notes: Command codes other than precharge and mode write are arbitrary picks.
package ddrarb_pkg;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int CMD_TIME_NS = 400;
    localparam int CMD_BUSY_CYC = (CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] BUSY_LOAD = 4'(CMD_BUSY_CYC);
    // Widths and reset values
    localparam int NCS = 2;
    localparam int IVW = 16;
    localparam int PCW = 8;
    localparam logic [IVW-1:0] TIMER_RST = 16'h0000;
    localparam logic [PCW-1:0] PEND_RST = 8'h00;
    localparam logic [2:0] INIT_LAST = 3'h4;
    // Command address fields
    localparam int PRE_ALL_BIT = 10;
    localparam int BANK_HI = 15;
    localparam int BANK_LO = 14;
    // Software command codes
    localparam logic [3:0] SW_INIT = 4'h1;
    localparam logic [3:0] SW_AREF = 4'h2;
    localparam logic [3:0] SW_SELF_REFRESH_CMD = 4'h3;
    localparam logic [3:0] SW_DPD = 4'h4;
    localparam logic [3:0] SW_CKE_EN = 4'h5;
    localparam logic [3:0] SW_CKE_DIS = 4'h6;
    localparam logic [3:0] SW_MRR = 4'h7;
    localparam logic [3:0] SW_PRE = 4'h9;
    localparam logic [3:0] SW_MRW = 4'hf;

    typedef enum logic [3:0] {
        DOP_NOP, DOP_ACCESS, DOP_PRE, DOP_PRECHARGE_ALL_CMD, DOP_CBR, DOP_SELF_REFRESH_CMD,
        DOP_SREX, DOP_DPD, DOP_MRS, DOP_EMRS, DOP_MRR
    } ddrarb_op_e;

    typedef enum logic [1:0] {SRC_NONE, SRC_ACC, SRC_REF, SRC_SW} ddrarb_src_e;

    typedef struct packed {
        logic refresh_auto_enable;
        logic self_refresh_auto_enable;
        logic [IVW-1:0] refresh_interval_count;
        logic [PCW-1:0] refresh_pending_limit;
        logic [PCW-1:0] refresh_drain_limit;
    } ddrarb_cfg_s;

    typedef struct packed {
        logic wr;
        logic enable;
        logic req_lock;
        logic cs;
        logic [3:0] code;
        logic [15:0] addr;
    } ddrarb_sw_s;

    typedef struct packed {
        logic valid;
        logic cs;
        ddrarb_op_e op;
        logic [15:0] addr;
    } ddrarb_cmd_s;
endpackage : ddrarb_pkg

//--- rtl/ddrarb_refcnt.sv
// Purpose: Refresh interval timer and owed-refresh counter of one chip select.
// Assumes: i_tick is a one-cycle pulse per rising memory clock edge.
// Notes: Interval of zero stops the timer.
`timescale 1ns/10ps
`default_nettype none
module ddrarb_refcnt
    import ddrarb_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_tick,
    input wire logic [IVW-1:0] i_interval,
    input wire logic i_pause,
    input wire logic i_cbr_done,
    // Status
    output logic [PCW-1:0] o_pending
);
    typedef struct packed {
        logic [IVW-1:0] timer;
        logic [PCW-1:0] pend;
    } ddrarb_rc_s;

    ddrarb_rc_s r_reg, r_next;
    logic expire;

    // Timer pauses in self refresh; an expiry and a AUTO_REFRESH_CMD together cancel out
    always_comb begin
        r_next = r_reg;
        expire = 1'b0;
        if (i_tick && !i_pause && i_interval != TIMER_RST) begin
            if (r_reg.timer >= i_interval - 16'h0001) begin
                r_next.timer = TIMER_RST;
                expire = 1'b1;
            end else begin
                r_next.timer = r_reg.timer + 16'h0001;
            end
        end
        if (expire && !i_cbr_done && r_reg.pend != 8'hff) begin
            r_next.pend = r_reg.pend + 8'h01;
        end else if (!expire && i_cbr_done && r_reg.pend != PEND_RST) begin
            r_next.pend = r_reg.pend - 8'h01;
        end
    end

    // State register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= '{timer: TIMER_RST, pend: PEND_RST};
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_pending = r_reg.pend;

    chk_pause_holds: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_pause && !i_cbr_done |=> r_reg.pend == $past(r_reg.pend))
        else $error("owed count moved while paused");
endmodule : ddrarb_refcnt
`default_nettype wire

//--- rtl/ddrarb_top.sv
// Purpose: Arbitration of queue access, refresh and software commands of a DDR controller.
// Assumes: Queue, config and software inputs are on the core clock; i_mem_clk is not.
// Notes: Every DRAM command occupies the command slot for CMD_BUSY_CYC cycles.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Three sources compete: queue access, refresh, software command of several kinds.
// - Fixed ranks 1 to 3 chosen by pending software command and refresh kind.
// - Automatic refresh enable puts a chip select into self refresh when idle.
// - Without self refresh, owed refreshes are counted and later paid by AUTO_REFRESH_CMD.
// - Interval per chip select is programmable; owed total is readable.
// - Owed total at limit blocks the queue and forces one AUTO_REFRESH_CMD first.
// - Interval timer pauses during self refresh and resumes on exit.
// - Before self refresh, owed CBRs are drained up to the drain limit.
// - All refresh state is kept separately per chip select.
// - A command issues when the trigger bit is written as zero with a code.
// - Commands wait for current work; lock holds queue access until cleared.
// - Command state flag shows busy; a trigger while busy is ignored.
// - Enabling clock enable control raises the clock request at once.
// - Initial sequence: precharge all, AUTO_REFRESH_CMD, AUTO_REFRESH_CMD, mode set, extended mode set.
// - Refresh, self refresh, deep power down and clock enable commands act as named.
// - A queued access raises the clock request; idle memory needs no clock.
module ddrarb_top
    import ddrarb_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_mem_clk,
    // Configuration per chip select
    input wire ddrarb_cfg_s [NCS-1:0] i_cfg,
    // Software command port
    input wire ddrarb_sw_s i_sw,
    // Request queue
    input wire logic i_acc_req,
    input wire logic i_acc_cs,
    output logic o_acc_grant,
    // DRAM command and status
    output ddrarb_cmd_s o_cmd,
    output logic o_cmd_state,
    output logic o_cke_ctrl,
    output logic o_clk_req,
    output logic [NCS-1:0] o_in_self_refresh_cmd,
    output logic [NCS-1:0][PCW-1:0] o_refresh_pending_count
);
    typedef struct packed {
        logic mclk_meta;
        logic mclk_sync;
        logic mclk_last;
        logic tick;
        logic [3:0] busy;
        logic sw_pend;
        logic [3:0] sw_code;
        logic sw_cs;
        logic [15:0] sw_addr;
        logic lock;
        logic [2:0] init_step;
        logic [NCS-1:0] in_self_refresh_cmd;
        logic [NCS-1:0][PCW-1:0] drain;
        logic [NCS-1:0] cbr_done;
        logic cke_ctrl;
        logic clk_req;
        logic cmd_state;
        logic acc_grant;
        ddrarb_cmd_s cmd;
    } ddrarb_st_s;

    ddrarb_st_s r_reg, r_next;
    logic [NCS-1:0][PCW-1:0] pend;
    logic ref_need, ref_cs, ref_self, forced;
    ddrarb_op_e ref_op;
    ddrarb_src_e win;
    logic acc_ok, sw_ok, idle;

    // Ranks {access, refresh, software}, smaller wins
    function automatic logic [5:0] ranks(input logic [3:0] code, input logic self_kind);
        logic [5:0] rk;
        rk = 6'h00;
        case (code)
            SW_INIT: rk = self_kind ? {2'h2, 2'h3, 2'h1} : {2'h3, 2'h2, 2'h1};
            SW_AREF, SW_MRR, SW_MRW: rk = self_kind ? {2'h2, 2'h3, 2'h1} : {2'h3, 2'h1, 2'h2};
            default: rk = self_kind ? {2'h1, 2'h2, 2'h3} : {2'h2, 2'h1, 2'h3};
        endcase
        return rk;
    endfunction : ranks

    // Lowest rank among active sources
    function automatic ddrarb_src_e pick(input logic a, input logic f, input logic s,
                                        input logic [5:0] rk);
        logic [2:0] best;
        ddrarb_src_e w;
        best = 3'h4;
        w = SRC_NONE;
        if (a && {1'b0, rk[5:4]} < best) begin
            best = {1'b0, rk[5:4]};
            w = SRC_ACC;
        end
        if (f && {1'b0, rk[3:2]} < best) begin
            best = {1'b0, rk[3:2]};
            w = SRC_REF;
        end
        if (s && {1'b0, rk[1:0]} < best) begin
            w = SRC_SW;
        end
        return w;
    endfunction : pick

    // One timer and owed counter per chip select
    for (genvar g = 0; g < NCS; g++) begin : g_cs
        ddrarb_refcnt u_refcnt (
            .i_core_clk(i_core_clk),
            .i_rst(i_rst),
            .i_tick(r_reg.tick),
            .i_interval(i_cfg[g].refresh_interval_count),
            .i_pause(r_reg.in_self_refresh_cmd[g]),
            .i_cbr_done(r_reg.cbr_done[g]),
            .o_pending(pend[g])
        );
    end

    // Refresh candidate: forced first, then drain or self refresh, then owed AUTO_REFRESH_CMD
    always_comb begin
        ref_need = 1'b0;
        ref_cs = 1'b0;
        ref_self = 1'b0;
        forced = 1'b0;
        ref_op = DOP_NOP;
        for (int c = NCS - 1; c >= 0; c--) begin
            if (r_reg.in_self_refresh_cmd[c]) begin
                // No refresh requested while asleep, whatever is owed
            end else if (pend[c] != PEND_RST && pend[c] >= i_cfg[c].refresh_pending_limit) begin
                forced = 1'b1;
                ref_need = 1'b1;
                ref_cs = 1'(c);
                ref_op = DOP_CBR;
            end else if (!forced && !i_acc_req && (i_cfg[c].refresh_auto_enable ||
                         i_cfg[c].self_refresh_auto_enable)) begin
                ref_need = 1'b1;
                ref_self = 1'b1;
                ref_cs = 1'(c);
                ref_op = (pend[c] != PEND_RST &&
                          r_reg.drain[c] < i_cfg[c].refresh_drain_limit) ? DOP_CBR : DOP_SELF_REFRESH_CMD;
            end else if (!forced && !i_acc_req && pend[c] != PEND_RST) begin
                ref_need = 1'b1;
                ref_cs = 1'(c);
                ref_op = DOP_CBR;
            end
        end
    end

    // Source selection
    always_comb begin
        idle = r_reg.busy == 4'h0;
        acc_ok = i_acc_req && !r_reg.lock && !forced;
        sw_ok = r_reg.sw_pend;
        if (!idle) begin
            win = SRC_NONE;
        end else if (forced) begin
            win = SRC_REF;
        end else begin
            win = pick(acc_ok, ref_need, sw_ok, ranks(r_reg.sw_code, ref_self));
        end
    end

    // Next state
    always_comb begin
        r_next = r_reg;
        r_next.mclk_meta = i_mem_clk;
        r_next.mclk_sync = r_reg.mclk_meta;
        r_next.mclk_last = r_reg.mclk_sync;
        r_next.tick = r_reg.mclk_sync && !r_reg.mclk_last;
        r_next.cmd = '{valid: 1'b0, cs: 1'b0, op: DOP_NOP, addr: 16'h0000};
        r_next.cbr_done = '0;
        r_next.acc_grant = 1'b0;
        r_next.clk_req = i_acc_req;
        if (!idle) begin
            r_next.busy = r_reg.busy - 4'h1;
        end
        // Software trigger: zero on the enable bit issues, ignored while busy
        if (i_sw.wr) begin
            r_next.lock = i_sw.req_lock;
            if (!i_sw.enable && r_reg.cmd_state) begin
                r_next.sw_pend = 1'b1;
                r_next.sw_code = i_sw.code;
                r_next.sw_cs = i_sw.cs;
                r_next.sw_addr = i_sw.addr;
                r_next.init_step = 3'h0;
            end
        end
        case (win)
            SRC_ACC: begin
                r_next.busy = BUSY_LOAD;
                r_next.cmd.valid = 1'b1;
                r_next.cmd.cs = i_acc_cs;
                if (r_reg.in_self_refresh_cmd[i_acc_cs]) begin
                    r_next.cmd.op = DOP_SREX; // Wake first; the timer resumes
                    r_next.in_self_refresh_cmd[i_acc_cs] = 1'b0;
                    r_next.drain[i_acc_cs] = PEND_RST;
                end else begin
                    r_next.cmd.op = DOP_ACCESS;
                    r_next.acc_grant = 1'b1;
                end
            end
            SRC_REF: begin
                r_next.busy = BUSY_LOAD;
                r_next.cmd.valid = 1'b1;
                r_next.cmd.cs = ref_cs;
                r_next.cmd.op = ref_op;
                if (ref_op == DOP_CBR) begin
                    r_next.cbr_done[ref_cs] = 1'b1;
                    if (ref_self) begin
                        r_next.drain[ref_cs] = r_reg.drain[ref_cs] + 8'h01;
                    end
                end else begin
                    r_next.in_self_refresh_cmd[ref_cs] = 1'b1;
                end
            end
            SRC_SW: begin
                r_next.busy = BUSY_LOAD;
                r_next.sw_pend = 1'b0;
                r_next.cmd.valid = 1'b1;
                r_next.cmd.cs = r_reg.sw_cs;
                case (r_reg.sw_code)
                    SW_INIT: begin
                        r_next.sw_pend = r_reg.init_step != INIT_LAST;
                        r_next.init_step = r_reg.init_step + 3'h1;
                        case (r_reg.init_step)
                            3'h0: r_next.cmd.op = DOP_PRECHARGE_ALL_CMD;
                            3'h1, 3'h2: r_next.cmd.op = DOP_CBR;
                            3'h3: r_next.cmd.op = DOP_MRS;
                            default: r_next.cmd.op = DOP_EMRS;
                        endcase
                        r_next.cmd.addr = r_reg.sw_addr;
                    end
                    SW_PRE: begin
                        r_next.cmd.op = r_reg.sw_addr[PRE_ALL_BIT] ? DOP_PRECHARGE_ALL_CMD : DOP_PRE;
                        r_next.cmd.addr = {r_reg.sw_addr[BANK_HI:BANK_LO], 14'h0000};
                    end
                    SW_AREF: r_next.cmd.op = DOP_CBR;
                    SW_SELF_REFRESH_CMD: begin
                        r_next.cmd.op = DOP_SELF_REFRESH_CMD;
                        r_next.in_self_refresh_cmd[r_reg.sw_cs] = 1'b1;
                    end
                    SW_DPD: r_next.cmd.op = DOP_DPD;
                    SW_CKE_EN: begin
                        r_next.cmd.valid = 1'b0;
                        r_next.cke_ctrl = 1'b1;
                        r_next.clk_req = 1'b1;
                    end
                    SW_CKE_DIS: begin
                        r_next.cmd.valid = 1'b0;
                        r_next.cke_ctrl = 1'b0;
                    end
                    SW_MRR: r_next.cmd.op = DOP_MRR;
                    SW_MRW: begin
                        r_next.cmd.op = DOP_MRS;
                        r_next.cmd.addr = r_reg.sw_addr;
                    end
                    default: r_next.cmd.valid = 1'b0;
                endcase
                if (r_reg.sw_code == SW_AREF) begin
                    r_next.cbr_done[r_reg.sw_cs] = 1'b1;
                end
            end
            default: begin
            end
        endcase
        r_next.cmd_state = !r_next.sw_pend;
    end

    // State register
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= '0;
            r_reg.cmd_state <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs
    assign o_acc_grant = r_reg.acc_grant;
    assign o_cmd = r_reg.cmd;
    assign o_cmd_state = r_reg.cmd_state;
    assign o_cke_ctrl = r_reg.cke_ctrl;
    assign o_clk_req = r_reg.clk_req;
    assign o_in_self_refresh_cmd = r_reg.in_self_refresh_cmd;
    assign o_refresh_pending_count = pend;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);

    sequence s_init_go;
        idle && win == SRC_SW && r_reg.sw_code == SW_INIT && r_reg.init_step == 3'h0;
    endsequence
    sequence s_init_tail;
        r_reg.cmd.op == DOP_PRECHARGE_ALL_CMD ##[4:60] r_reg.cmd.valid && r_reg.cmd.op == DOP_CBR;
    endsequence

    chk_init_order: assert property (s_init_go |=> s_init_tail)
        else $error("initial sequence out of order");
    chk_busy_ignore: assert property (!r_reg.cmd_state && i_sw.wr && !i_sw.enable &&
        r_reg.sw_code != i_sw.code |=> r_reg.sw_code == $past(r_reg.sw_code))
        else $error("trigger taken while busy");
    chk_forced_top: assert property (idle && forced |=>
        r_reg.cmd.valid && r_reg.cmd.op == DOP_CBR && !r_reg.acc_grant)
        else $error("forced refresh not first");
    chk_lock_hold: assert property (r_reg.lock && !i_sw.wr |=> !r_reg.acc_grant)
        else $error("access granted under lock");
    chk_cke_clkreq: assert property (idle && win == SRC_SW && r_reg.sw_code == SW_CKE_EN
        |=> o_clk_req && o_cke_ctrl)
        else $error("clock request missing on enable");
    chk_prech_bank: assert property (r_reg.cmd.valid && r_reg.cmd.op == DOP_PRE |->
        $past(r_reg.sw_addr[PRE_ALL_BIT]) == 1'b0)
        else $error("single precharge with all-bank bit");
    chk_self_refresh_cmd_drain: assert property (idle && win == SRC_REF && ref_op == DOP_SELF_REFRESH_CMD |->
        pend[ref_cs] == PEND_RST || r_reg.drain[ref_cs] >= i_cfg[ref_cs].refresh_drain_limit)
        else $error("self refresh with drain unfinished");
    chk_grant_busy: assert property (r_reg.acc_grant |-> r_reg.busy == BUSY_LOAD ##1
        r_reg.busy == BUSY_LOAD - 4'h1)
        else $error("grant without command slot");
    chk_clk_req_acc: assert property (i_acc_req |=> o_clk_req)
        else $error("no clock request for queued access");
endmodule : ddrarb_top
`default_nettype wire

//--- test/ddrarb_mem_model.sv
// Purpose: Far side model: memory clock source and DRAM command log.
// Assumes: Commands are sampled on the core clock.
// Notes: Memory clock runs free so refresh timers keep ticking.
`timescale 1ns/10ps
`default_nettype none
module ddrarb_mem_model
    import ddrarb_pkg::*;
(
    // Clocks
    input wire logic i_core_clk,
    output logic o_mem_clk,
    // DRAM command bus
    input wire ddrarb_cmd_s i_cmd
);
    ddrarb_cmd_s log_q [0:63];
    int n = 0;
    // Memory clock, 800 ns period, unrelated to the core clock
    initial begin
        o_mem_clk = 1'b0;
        #37;
        forever #400 o_mem_clk = ~o_mem_clk;
    end
    // Log the first 64 issued commands in arrival order
    always @(posedge i_core_clk) begin
        if (i_cmd.valid === 1'b1 && n < 64) begin
            log_q[n] <= i_cmd;
            n <= n + 1;
        end
    end
endmodule : ddrarb_mem_model
`default_nettype wire

//--- test/tb_ddrarb_top.sv
// Purpose: Self-checking bench of the DDR arbiter/refresh block.
// Assumes: Inputs change on the falling edge of the core clock.
// Notes: Commands are judged from the far side model's log; the forced refresh is judged on the command bus.
`timescale 1ns/10ps
`default_nettype none
module tb_ddrarb_top;
    import ddrarb_pkg::*;
    logic clk;
    logic rst;
    logic mem_clk;
    ddrarb_cfg_s [NCS-1:0] cfg;
    ddrarb_sw_s sw;
    logic acc_req;
    logic acc_cs;
    logic acc_grant;
    ddrarb_cmd_s cmd;
    logic cmd_state;
    logic cke_ctrl;
    logic clk_req;
    logic [NCS-1:0] in_self_refresh_cmd;
    logic [NCS-1:0][PCW-1:0] pend;
    int n_errors = 0;
    int samples_checked = 0;
    int grants = 0;
    int cyc = 0;

    ddrarb_top DUT (.i_core_clk(clk), .i_rst(rst), .i_mem_clk(mem_clk), .i_cfg(cfg),
        .i_sw(sw), .i_acc_req(acc_req), .i_acc_cs(acc_cs), .o_acc_grant(acc_grant),
        .o_cmd(cmd), .o_cmd_state(cmd_state), .o_cke_ctrl(cke_ctrl), .o_clk_req(clk_req),
        .o_in_self_refresh_cmd(in_self_refresh_cmd), .o_refresh_pending_count(pend));
    ddrarb_mem_model mem (.i_core_clk(clk), .o_mem_clk(mem_clk), .i_cmd(cmd));

    // Core clock, 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Grant counter and run limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (acc_grant === 1'b1) begin
            grants <= grants + 1;
        end
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
    end

    // Compare seen against expected
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One write of the software command port
    task sw_wr(input logic en, input logic lk, input logic [3:0] c, input logic s,
               input logic [15:0] a);
        @(negedge clk);
        sw <= '{wr: 1'b1, enable: en, req_lock: lk, cs: s, code: c, addr: a};
        @(negedge clk);
        sw.wr <= 1'b0;
    endtask : sw_wr

    // Bounded wait for the ready flag
    task wait_ready;
        int k;
        for (k = 0; k < 100 && cmd_state !== 1'b1; k++) @(negedge clk);
        chk(cmd_state, 1'b1);
        repeat (3) @(negedge clk);
    endtask : wait_ready

    // Init sequence, with a second trigger while busy
    task t_init;
        int n0;
        ddrarb_op_e exp_op [0:4];
        exp_op = '{DOP_PRECHARGE_ALL_CMD, DOP_CBR, DOP_CBR, DOP_MRS, DOP_EMRS};
        n0 = mem.n;
        sw_wr(1'b0, 1'b1, SW_INIT, 1'b0, 16'h0000);
        chk(cmd_state, 1'b0);
        sw_wr(1'b0, 1'b1, SW_AREF, 1'b0, 16'h0000);
        wait_ready();
        chk(mem.n - n0, 5);
        for (int i = 0; i < 5; i++) chk(mem.log_q[n0 + i].op, exp_op[i]);
        $display("test init done");
    endtask : t_init

    // Command codes SW_AREF, SW_PRE (twice), SW_MRW, self refresh and SW_DPD and their DRAM commands
    task t_cmds;
        int n0;
        logic [3:0] code [0:5];
        ddrarb_op_e op [0:5];
        logic [15:0] adr [0:5];
        logic s [0:5];
        code = '{SW_AREF, SW_PRE, SW_PRE, SW_MRW, SW_SELF_REFRESH_CMD, SW_DPD};
        op = '{DOP_CBR, DOP_PRECHARGE_ALL_CMD, DOP_PRE, DOP_MRS, DOP_SELF_REFRESH_CMD, DOP_DPD};
        adr = '{16'h0000, 16'h0400, 16'h8000, 16'h0123, 16'h0000, 16'h0000};
        s = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 6; i++) begin
            n0 = mem.n;
            sw_wr(1'b0, 1'b0, code[i], s[i], adr[i]);
            wait_ready();
            chk(mem.n - n0, 1);
            chk(mem.log_q[n0].op, op[i]);
            chk(mem.log_q[n0].cs, s[i]);
            if (i == 2 || i == 3) chk(mem.log_q[n0].addr, adr[i]);
        end
        $display("test cmds done");
    endtask : t_cmds

    // Clock enable control commands; the clock request stands only in the issue cycle
    task t_cke;
        int n0;
        int k;
        n0 = mem.n;
        sw_wr(1'b0, 1'b0, SW_CKE_EN, 1'b0, 16'h0000);
        for (k = 0; k < 20 && cmd_state !== 1'b1; k++) @(negedge clk);
        chk(clk_req, 1'b1);
        wait_ready();
        chk(cke_ctrl, 1'b1);
        sw_wr(1'b0, 1'b0, SW_CKE_DIS, 1'b0, 16'h0000);
        wait_ready();
        chk(cke_ctrl, 1'b0);
        chk(mem.n - n0, 0);
        $display("test cke done");
    endtask : t_cke

    // Lock holds queue access until cleared
    task t_lock;
        int g0;
        int k;
        sw_wr(1'b1, 1'b1, SW_AREF, 1'b0, 16'h0000);
        g0 = grants;
        acc_cs <= 1'b0;
        acc_req <= 1'b1;
        repeat (20) @(negedge clk);
        chk(grants - g0, 0);
        sw_wr(1'b1, 1'b0, SW_AREF, 1'b0, 16'h0000);
        for (k = 0; k < 50 && grants == g0; k++) @(negedge clk);
        acc_req <= 1'b0;
        chk(grants - g0, 1);
        chk(clk_req, 1'b1);
        chk(mem.log_q[mem.n - 1].op, DOP_ACCESS);
        repeat (6) @(negedge clk);
        $display("test lock done");
    endtask : t_lock

    // Busy queue lets owed refreshes reach the limit; then drain and self refresh
    task t_refresh;
        int n0;
        int k;
        acc_cs <= 1'b0;
        acc_req <= 1'b1;
        cfg[0].refresh_interval_count <= 16'h0002;
        cfg[0].refresh_pending_limit <= 8'h02;
        for (k = 0; k < 400 && pend[0] != 8'h02; k++) @(negedge clk);
        chk(pend[0], 8'h02);
        chk(pend[1], 8'h00);
        cfg[0].refresh_interval_count <= 16'h0000;
        for (k = 0; k < 20 && !(cmd.valid === 1'b1 && cmd.op == DOP_CBR); k++) @(negedge clk);
        chk(cmd.op, DOP_CBR);
        chk(cmd.cs, 1'b0);
        chk(acc_grant, 1'b0);
        @(negedge clk);
        chk(pend[0], 8'h01);
        n0 = mem.n;
        cfg[0].self_refresh_auto_enable <= 1'b1;
        cfg[0].refresh_drain_limit <= 8'h01;
        acc_req <= 1'b0;
        for (k = 0; k < 40 && in_self_refresh_cmd[0] !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        chk(mem.n - n0, 2);
        chk(mem.log_q[n0].op, DOP_CBR);
        chk(mem.log_q[n0 + 1].op, DOP_SELF_REFRESH_CMD);
        chk(mem.log_q[n0 + 1].cs, 1'b0);
        chk(pend[0], 8'h00);
        $display("test refresh done");
    endtask : t_refresh

    // Power down: refresh off, then precharge all, clock enable, deep power down
    task t_power;
        int n0;
        cfg <= '0;
        n0 = mem.n;
        sw_wr(1'b0, 1'b1, SW_PRE, 1'b0, 16'h0400);
        wait_ready();
        sw_wr(1'b0, 1'b1, SW_CKE_EN, 1'b0, 16'h0000);
        wait_ready();
        sw_wr(1'b0, 1'b1, SW_DPD, 1'b0, 16'h0000);
        wait_ready();
        chk(mem.n - n0, 2);
        chk(mem.log_q[n0].op, DOP_PRECHARGE_ALL_CMD);
        chk(mem.log_q[n0 + 1].op, DOP_DPD);
        chk(cke_ctrl, 1'b1);
        $display("test power done");
    endtask : t_power

    // Final report and verdict
    task test_done;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // Main sequence
    initial begin
        rst = 1'b1;
        cfg = '0;
        sw = '0;
        sw.enable = 1'b1;
        acc_req = 1'b0;
        acc_cs = 1'b0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk(cmd_state, 1'b1);
        chk(pend, 16'h0000);
        t_init();
        t_cmds();
        t_cke();
        t_lock();
        t_refresh();
        t_power();
        test_done();
    end
endmodule : tb_ddrarb_top
`default_nettype wire
